//--- design/txpe_pkg.sv
// Constants, register map and carrier types of the transmit packet engine.
// Assumes a 50 MHz core clock; all other timing is derived from it.
package txpe_pkg;
  localparam int CLK_MHZ = 50;
  localparam int BIT_NS = 3200;
  localparam int BIT_CYCLES = (BIT_NS * CLK_MHZ) / 1000;

  localparam logic [6:0] ADR_STATE = 7'h00;
  localparam logic [6:0] ADR_LOCK = 7'h0C;
  localparam logic [6:0] ADR_PKT = 7'h0D;
  localparam logic [6:0] ADR_BIAS = 7'h17;
  localparam logic [6:0] ADR_SYNC_LO = 7'h19;
  localparam logic [6:0] ADR_SYNC_HI = 7'h1C;
  localparam logic [6:0] ADR_DATA = 7'h1D;

  localparam logic [7:0] RST_STATE = 8'h7F;
  localparam logic [7:0] RST_LOCK = 8'h31;
  localparam logic [7:0] RST_PKT = 8'hB6;
  localparam logic [7:0] RST_BIAS = 8'h99;
  localparam logic [7:0] RST_SYNC = 8'hE5;

  localparam logic [7:0] PREAMBLE_BYTE = 8'hAA;
  localparam logic [1:0] ST_TX = 2'h3;
  localparam logic [1:0] ST_DOWN = 2'h0;
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [15:0] CRC16_POLY = 16'h1021;

  typedef struct packed {
    logic [1:0] op_state;
    logic [2:0] amp_level;
    logic ref_out_on;
    logic sync_mode;
    logic load_en;
  } txpe_state_t;

  typedef struct packed {
    logic [1:0] batt_lvl;
    logic [1:0] ldo_cfg;
    logic tx_lock_wait;
    logic amp_auto_off;
    logic amp_lock_gate;
    logic lock_en;
  } txpe_lock_t;

  typedef struct packed {
    logic bit_io;
    logic manchester;
    logic [1:0] check_sel;
    logic [1:0] sync_word_count;
    logic [1:0] preamble_len;
  } txpe_pkt_t;

  typedef struct packed {
    logic [3:0] amp_bias;
    logic [3:0] driver_bias;
  } txpe_bias_t;

  typedef enum logic [2:0] {
    FR_IDLE, FR_WAIT, FR_PRE, FR_SYNC, FR_LEN, FR_PAY, FR_CHK, FR_TAIL
  } txpe_frame_t;
endpackage

//--- design/txpe_sync2.sv
// Two flip-flop synchroniser for pins from outside the core clock.
// Assumes each bit is an independent level.
`timescale 1ns/1ps
`default_nettype none
module txpe_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule // txpe_sync2
`default_nettype wire

//--- design/txpe_buf2.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes both sides run on the core clock.
`timescale 1ns/1ps
`default_nettype none
module txpe_buf2 #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem_ff [2];
  logic [1:0] cnt_ff;
  logic rd_ff;
  logic wr_ff;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = cnt_ff != 2'h2;
  assign out_valid = cnt_ff != 2'h0;
  assign out_data = mem_ff[rd_ff];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_ff <= 2'h0;
      rd_ff <= 1'b0;
      wr_ff <= 1'b0;
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= in_data;
        wr_ff <= ~wr_ff;
      end
      if (pop) begin
        rd_ff <= ~rd_ff;
      end
      cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // txpe_buf2
`default_nettype wire

//--- design/txpe_ctrl.sv
// Transmit packet engine: serial register port, framer, state and amp control.
// Assumes the host clocks the port far slower than core_clk.
//
// What this block does
// R01: Preamble of 1-4 bytes 10101010
// R02: Sync word 1-4 bytes from registers 28-25
// R03: Host gives frame length 2 to 255/checks
// R04: Optional check field of 0, 1, 2 bytes
// R05: Select rising applies settings, starts synthesizer, amp
// R06: Host writes transmit buffer at address 29
// R07: Eighth frame length bit starts modulation
// R08: Lock wait holds modulation until tuned, locked
// R09: Without lock wait host checks lock first
// R10: Ready during last sync bit, then buffer free
// R11: Host refills buffer between ready falling edges
// R12: Ready on last payload bit and check bytes
// R13: Output lags internal bit stream one bit
// R14: Host holds select low while gated amp
// R15: Auto amp-off after last bit, synthesizer stays
// R16: Next buffer byte in transmit is frame length
// R17: Sample on falling, drive reads on rising
// R18: First octet is address then read bit
// R19: Host transfers whole octets, MSB first
// R20: Write session ends by select rising load
// R21: State field: down, standby, transmit decode
// R22: Amp level zero off unless lock gated
// R23: Sync sent from address 28 down to 25
// R24: Address 29 does not auto increment
// R25: Select high resets serial counters
`timescale 1ns/1ps
`default_nettype none
module txpe_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic port_select_low_n,
  input wire logic serial_clk,
  input wire logic serial_data_i,
  output logic serial_data_o,
  output logic serial_data_oe,
  input wire logic lock_detect,
  output logic tx_bit,
  output logic mod_active,
  output logic ready_strobe,
  output logic amp_on,
  output logic [2:0] amp_level,
  output logic [7:0] amp_bias_ctrl,
  output logic synth_on,
  output logic xco_on,
  output logic ref_out_en,
  output logic buf_ready
);
  logic sen_n_s, sck_s, sio_s, ld_s;
  logic sen_d_ff, sck_d_ff;
  logic [2:0] bit_cnt_ff;
  logic first_ff, rw_ff;
  logic [6:0] addr_ff, sh_in_ff;
  logic [7:0] rd_sh_ff;
  txpe_pkg::txpe_state_t st_sh_ff;
  logic [7:0] lk_sh_ff, pk_sh_ff, bias_sh_ff;
  txpe_pkg::txpe_state_t st_ff;
  txpe_pkg::txpe_lock_t lk_ff;
  txpe_pkg::txpe_pkt_t pk_ff;
  logic [7:0] bias_ff;
  logic [7:0] sync_ff [4];
  logic load_ff, amp_off_ff;
  txpe_pkg::txpe_frame_t fr_ff;
  logic [7:0] tmr_ff, len_ff, pay_cnt_ff, fsh_ff;
  logic [2:0] bit_idx_ff;
  logic [1:0] cnt_ff, sync_sel_ff;
  logic chk_left_ff;
  logic [15:0] crc_ff;
  logic wr_valid_ff;
  logic [7:0] wr_byte_ff;
  logic bo_valid, pop;
  logic [7:0] bo_data;
  logic in_rdy;

  function automatic logic [15:0] crc_step(input logic [15:0] c,
                                           input logic b,
                                           input logic wide);
    logic [15:0] r;
    r = c;
    if (wide) begin
      r = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? txpe_pkg::CRC16_POLY : 16'h0000);
    end else begin
      r[15:8] = 8'h00;
      r[7:0] = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? txpe_pkg::CRC8_POLY : 8'h00);
    end
    return r;
  endfunction

  // Resets to idle pin levels: deselected, clock low
  txpe_sync2 #(.W(4), .RST_VAL(4'h8)) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .async_in({port_select_low_n, serial_clk, serial_data_i, lock_detect}),
    .sync_out({sen_n_s, sck_s, sio_s, ld_s})
  );

  // Serial edge and octet decode
  wire sck_fall = sck_d_ff && !sck_s && !sen_n_s; // R17
  wire sck_rise = !sck_d_ff && sck_s && !sen_n_s; // R17
  wire sen_rise = !sen_d_ff && sen_n_s;
  wire oct_done = sck_fall && bit_cnt_ff == 3'h7;
  wire [7:0] oct = {sh_in_ff, sio_s};
  wire [6:0] oct_addr = oct[7:1]; // R18
  wire wr_oct = oct_done && !first_ff && !rw_ff;
  wire [6:0] rd_addr = first_ff ? oct_addr : addr_ff + 7'h01;
  wire is_sync_adr = addr_ff >= txpe_pkg::ADR_SYNC_LO &&
                     addr_ff <= txpe_pkg::ADR_SYNC_HI;
  wire [1:0] sync_idx = 2'(addr_ff - txpe_pkg::ADR_SYNC_LO);
  wire rd_sync = rd_addr >= txpe_pkg::ADR_SYNC_LO &&
                 rd_addr <= txpe_pkg::ADR_SYNC_HI;
  wire [7:0] rd_mux =
    rd_addr == txpe_pkg::ADR_STATE ? st_sh_ff :
    rd_addr == txpe_pkg::ADR_LOCK ? lk_sh_ff :
    rd_addr == txpe_pkg::ADR_PKT ? pk_sh_ff :
    rd_addr == txpe_pkg::ADR_BIAS ? bias_sh_ff :
    rd_sync ? sync_ff[2'(rd_addr - txpe_pkg::ADR_SYNC_LO)] : 8'h00;
  wire load_now = sen_rise && st_sh_ff.load_en;

  // State decode
  wire is_tx = st_ff.op_state == txpe_pkg::ST_TX; // R21
  wire is_up = st_ff.op_state != txpe_pkg::ST_DOWN; // R21
  wire [1:0] chk_n = !pk_ff.check_sel[1] ? 2'h0 :
                     pk_ff.check_sel[0] ? 2'h2 : 2'h1; // R04
  wire amp_req = is_tx && !amp_off_ff &&
    (lk_ff.amp_lock_gate ? (ld_s && !load_ff) // R22
                         : st_ff.amp_level != 3'h0); // R22
  wire bit_tick = fr_ff > txpe_pkg::FR_WAIT &&
                  tmr_ff == 8'(txpe_pkg::BIT_CYCLES - 1);
  wire byte_end = bit_tick && bit_idx_ff == 3'h7;
  wire go = !lk_ff.tx_lock_wait || (synth_on && amp_on && ld_s); // R08
  wire [7:0] pay_len = len_ff - {6'h00, chk_n};
  wire rdy_phase = (fr_ff == txpe_pkg::FR_SYNC && cnt_ff == 2'h0) ||
                   fr_ff == txpe_pkg::FR_LEN || fr_ff == txpe_pkg::FR_PAY ||
                   fr_ff == txpe_pkg::FR_CHK; // R10 R12
  wire [15:0] crc_out = chk_n == 2'h2 ? crc_ff : {crc_ff[7:0], 8'h00};
  wire [15:0] crc_nxt = crc_step(crc_ff, fsh_ff[7], chk_n == 2'h2);
  assign pop = (fr_ff == txpe_pkg::FR_IDLE && is_tx && bo_valid) ||
               (byte_end && ((fr_ff == txpe_pkg::FR_LEN && pay_len != 8'h00) ||
               (fr_ff == txpe_pkg::FR_PAY && pay_cnt_ff > 8'h01)));

  txpe_buf2 #(.W(8)) u_buf (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(wr_valid_ff),
    .in_ready(in_rdy),
    .in_data(wr_byte_ff),
    .out_valid(bo_valid),
    .out_ready(pop),
    .out_data(bo_data)
  );

  // Serial port
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sen_d_ff <= 1'b1;
      sck_d_ff <= 1'b0;
      bit_cnt_ff <= 3'h0;
      first_ff <= 1'b1;
      rw_ff <= 1'b0;
      addr_ff <= 7'h00;
      sh_in_ff <= 7'h00;
      rd_sh_ff <= 8'h00;
      serial_data_o <= 1'b0;
      serial_data_oe <= 1'b0;
      wr_valid_ff <= 1'b0;
      wr_byte_ff <= 8'h00;
    end else begin
      sen_d_ff <= sen_n_s;
      sck_d_ff <= sck_s;
      wr_valid_ff <= wr_oct && addr_ff == txpe_pkg::ADR_DATA; // R06
      if (wr_oct) begin
        wr_byte_ff <= oct;
      end
      if (sen_n_s) begin
        bit_cnt_ff <= 3'h0; // R25
        first_ff <= 1'b1; // R25
        serial_data_oe <= 1'b0;
      end else if (sck_fall) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        sh_in_ff <= oct[6:0];
        if (oct_done && first_ff) begin
          addr_ff <= oct_addr; // R18
          rw_ff <= oct[0]; // R18
          first_ff <= 1'b0;
          rd_sh_ff <= rd_mux;
        end else if (oct_done) begin
          rd_sh_ff <= rd_mux;
          if (addr_ff != txpe_pkg::ADR_DATA) begin
            addr_ff <= addr_ff + 7'h01; // R24
          end
        end
      end else if (sck_rise && rw_ff && !first_ff) begin
        serial_data_o <= rd_sh_ff[7]; // R17
        serial_data_oe <= 1'b1;
        rd_sh_ff <= {rd_sh_ff[6:0], 1'b0};
      end
    end
  end

  // Registers: shadow written, active on load; sync words written directly
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_sh_ff <= txpe_pkg::RST_STATE;
      lk_sh_ff <= txpe_pkg::RST_LOCK;
      pk_sh_ff <= txpe_pkg::RST_PKT;
      bias_sh_ff <= txpe_pkg::RST_BIAS;
      st_ff <= txpe_pkg::RST_STATE;
      lk_ff <= txpe_pkg::RST_LOCK;
      pk_ff <= txpe_pkg::RST_PKT;
      bias_ff <= txpe_pkg::RST_BIAS;
      for (int i = 0; i < 4; i++) begin
        sync_ff[i] <= txpe_pkg::RST_SYNC;
      end
      load_ff <= 1'b0;
    end else begin
      load_ff <= load_now;
      if (wr_oct && addr_ff == txpe_pkg::ADR_STATE) st_sh_ff <= oct;
      if (wr_oct && addr_ff == txpe_pkg::ADR_LOCK) lk_sh_ff <= oct;
      if (wr_oct && addr_ff == txpe_pkg::ADR_PKT) pk_sh_ff <= oct;
      if (wr_oct && addr_ff == txpe_pkg::ADR_BIAS) bias_sh_ff <= oct;
      if (wr_oct && is_sync_adr) sync_ff[sync_idx] <= oct;
      if (load_now) begin
        st_ff <= st_sh_ff; // R05 R20
        lk_ff <= lk_sh_ff; // R20
        pk_ff <= pk_sh_ff; // R20
        bias_ff <= bias_sh_ff;
      end
    end
  end

  // Framer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fr_ff <= txpe_pkg::FR_IDLE;
      tmr_ff <= 8'h00;
      bit_idx_ff <= 3'h0;
      len_ff <= 8'h00;
      pay_cnt_ff <= 8'h00;
      fsh_ff <= 8'h00;
      cnt_ff <= 2'h0;
      sync_sel_ff <= 2'h3;
      chk_left_ff <= 1'b0;
      crc_ff <= 16'h0000;
      tx_bit <= 1'b0;
      mod_active <= 1'b0;
      ready_strobe <= 1'b0;
      amp_off_ff <= 1'b0;
    end else begin
      if (fr_ff > txpe_pkg::FR_WAIT) begin
        tmr_ff <= bit_tick ? 8'h00 : tmr_ff + 8'h01;
      end
      if (bit_tick) begin
        tx_bit <= fsh_ff[7]; // R13
        fsh_ff <= {fsh_ff[6:0], 1'b0};
        bit_idx_ff <= bit_idx_ff + 3'h1;
        if (fr_ff == txpe_pkg::FR_PAY) begin
          crc_ff <= crc_nxt;
        end
      end
      ready_strobe <= rdy_phase && bit_idx_ff == 3'h7 &&
                      fr_ff > txpe_pkg::FR_WAIT; // R10 R12
      if (load_now) begin
        amp_off_ff <= 1'b0; // R15
      end
      case (fr_ff)
        txpe_pkg::FR_IDLE: begin
          if (is_tx && bo_valid) begin
            len_ff <= bo_data; // R07 R16
            amp_off_ff <= 1'b0; // R16
            fr_ff <= txpe_pkg::FR_WAIT;
          end
        end
        txpe_pkg::FR_WAIT: begin
          if (!is_tx) begin
            fr_ff <= txpe_pkg::FR_IDLE;
          end else if (go) begin // R08
            fsh_ff <= txpe_pkg::PREAMBLE_BYTE; // R01
            cnt_ff <= pk_ff.preamble_len; // R01
            tmr_ff <= 8'h00;
            bit_idx_ff <= 3'h0;
            crc_ff <= 16'h0000;
            mod_active <= 1'b1; // R07
            fr_ff <= txpe_pkg::FR_PRE;
          end
        end
        txpe_pkg::FR_PRE: begin
          if (byte_end && cnt_ff != 2'h0) begin
            fsh_ff <= txpe_pkg::PREAMBLE_BYTE; // R01
            cnt_ff <= cnt_ff - 2'h1;
          end else if (byte_end) begin
            fsh_ff <= sync_ff[3]; // R23
            sync_sel_ff <= 2'h2;
            cnt_ff <= pk_ff.sync_word_count; // R02
            fr_ff <= txpe_pkg::FR_SYNC;
          end
        end
        txpe_pkg::FR_SYNC: begin
          if (byte_end && cnt_ff != 2'h0) begin
            fsh_ff <= sync_ff[sync_sel_ff]; // R02 R23
            sync_sel_ff <= sync_sel_ff - 2'h1;
            cnt_ff <= cnt_ff - 2'h1;
          end else if (byte_end) begin
            fsh_ff <= len_ff;
            fr_ff <= txpe_pkg::FR_LEN;
          end
        end
        txpe_pkg::FR_LEN: begin
          if (byte_end) begin
            pay_cnt_ff <= pay_len;
            chk_left_ff <= chk_n == 2'h2;
            if (pay_len != 8'h00) begin
              fsh_ff <= bo_valid ? bo_data : 8'h00;
              fr_ff <= txpe_pkg::FR_PAY;
            end else if (chk_n != 2'h0) begin
              fsh_ff <= crc_out[15:8];
              fr_ff <= txpe_pkg::FR_CHK;
            end else begin
              fr_ff <= txpe_pkg::FR_TAIL;
            end
          end
        end
        txpe_pkg::FR_PAY: begin
          if (byte_end && pay_cnt_ff > 8'h01) begin
            fsh_ff <= bo_valid ? bo_data : 8'h00;
            pay_cnt_ff <= pay_cnt_ff - 8'h01;
          end else if (byte_end && chk_n != 2'h0) begin
            fsh_ff <= chk_n == 2'h2 ? crc_nxt[15:8] : crc_nxt[7:0]; // R04
            fr_ff <= txpe_pkg::FR_CHK;
          end else if (byte_end) begin
            fr_ff <= txpe_pkg::FR_TAIL;
          end
        end
        txpe_pkg::FR_CHK: begin
          if (byte_end && chk_left_ff) begin
            fsh_ff <= crc_ff[7:0]; // R04
            chk_left_ff <= 1'b0;
          end else if (byte_end) begin
            fr_ff <= txpe_pkg::FR_TAIL;
          end
        end
        txpe_pkg::FR_TAIL: begin
          if (bit_tick) begin
            mod_active <= 1'b0; // R13
            amp_off_ff <= lk_ff.amp_auto_off; // R15
            fr_ff <= txpe_pkg::FR_IDLE;
          end
        end
        default: begin
          fr_ff <= txpe_pkg::FR_IDLE;
        end
      endcase
    end
  end

  // Analog control outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      amp_on <= 1'b0;
      amp_level <= 3'h0;
      amp_bias_ctrl <= txpe_pkg::RST_BIAS;
      synth_on <= 1'b0;
      xco_on <= 1'b0;
      ref_out_en <= 1'b0;
      buf_ready <= 1'b0;
    end else begin
      amp_on <= amp_req; // R05 R15 R22
      amp_level <= st_ff.amp_level;
      amp_bias_ctrl <= bias_ff;
      synth_on <= is_tx; // R05 R15 R21
      xco_on <= is_up; // R21
      ref_out_en <= is_up && st_ff.ref_out_on; // R21
      buf_ready <= in_rdy;
    end
  end
endmodule // txpe_ctrl
`default_nettype wire

//--- sim/txpe_ctrl_asserts.sv
// Concurrent checks on the transmit packet engine ports.
// Assumes binding onto txpe_ctrl and a single core_clk domain.
`timescale 1ns/1ps
`default_nettype none
module txpe_ctrl_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic port_select_low_n,
  input wire logic serial_clk,
  input wire logic serial_data_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe,
  input wire logic lock_detect,
  input wire logic tx_bit,
  input wire logic mod_active,
  input wire logic ready_strobe,
  input wire logic amp_on,
  input wire logic [2:0] amp_level,
  input wire logic [7:0] amp_bias_ctrl,
  input wire logic synth_on,
  input wire logic xco_on,
  input wire logic ref_out_en,
  input wire logic buf_ready
);
  logic [7:0] rdy_cnt_ff;
  logic [11:0] gap_cnt_ff;
  logic [15:0] mod_cnt_ff;
  // Ready width, time since ready, time since modulation start
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdy_cnt_ff <= 8'h00;
      gap_cnt_ff <= 12'h000;
      mod_cnt_ff <= 16'h0000;
    end else begin
      rdy_cnt_ff <= ready_strobe ? rdy_cnt_ff + 8'h01 : 8'h00;
      if (ready_strobe)
        gap_cnt_ff <= 12'h000;
      else if (gap_cnt_ff != 12'hFFF)
        gap_cnt_ff <= gap_cnt_ff + 12'h001;
      if (!mod_active)
        mod_cnt_ff <= 16'h0000;
      else if (mod_cnt_ff != 16'hFFFF)
        mod_cnt_ff <= mod_cnt_ff + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  AST_DESELECT_OE: assert property (
    $rose(port_select_low_n) |-> ##[1:6] !serial_data_oe)
    else $error("data pin still driven after deselect");
  AST_STANDBY_XCO: assert property (
    synth_on |-> xco_on) else $error("synth on without oscillator");
  AST_AMP_IN_TX: assert property (
    amp_on |-> synth_on) else $error("amp on outside transmit");
  AST_MOD_IN_TX: assert property (
    mod_active |-> synth_on) else $error("modulating without synth");
  AST_READY_WIDTH: assert property (
    $fell(ready_strobe) |-> rdy_cnt_ff == txpe_pkg::BIT_CYCLES)
    else $error("ready strobe not one bit long");
  AST_READY_IN_MOD: assert property (
    ready_strobe |-> mod_active) else $error("ready outside packet");
  AST_HEADER_LEN: assert property (
    $rose(ready_strobe) |-> mod_cnt_ff >= 16'h0960)
    else $error("ready before preamble and sync sent");
  AST_TAIL_LAG: assert property (
    $fell(mod_active) |-> gap_cnt_ff >= 12'h096 && gap_cnt_ff <= 12'h0AA)
    else $error("modulation end not one bit after ready");
endmodule // txpe_ctrl_asserts
`default_nettype wire

//--- sim/txpe_host_model.sv
// Host side of the three-wire register port, 160 ns serial clock.
// Assumes core_clk at 50 MHz; serial clock rests low outside octets.
`timescale 1ns/1ps
`default_nettype none
module txpe_host_model (
  input wire logic core_clk,
  output logic port_select_low_n,
  output logic serial_clk,
  output logic serial_data_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe
);
  logic drv_ff;
  logic dat_ff;
  // Shared data wire; released line shows inverse of last bit
  assign serial_data_i = serial_data_oe ? serial_data_o :
    (drv_ff ? dat_ff : ~dat_ff);
  initial begin
    port_select_low_n = 1'b1;
    serial_clk = 1'b0;
    drv_ff = 1'b1;
    dat_ff = 1'b0;
  end
  task automatic xfer(input logic [7:0] wb, input logic drv,
                      output logic [7:0] rb);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk);
      serial_clk <= 1'b1;
      dat_ff <= wb[i];
      drv_ff <= drv;
      repeat (4) @(posedge core_clk);
      serial_clk <= 1'b0;
      repeat (3) @(posedge core_clk);
      rb[i] = serial_data_i;
    end
  endtask
  task automatic open_s(input logic [6:0] a, input logic rw);
    logic [7:0] d;
    @(posedge core_clk);
    port_select_low_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    xfer({a, rw}, 1'b1, d);
  endtask
  task automatic close_s();
    repeat (4) @(posedge core_clk);
    port_select_low_n <= 1'b1;
    drv_ff <= 1'b1;
    repeat (8) @(posedge core_clk);
  endtask
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    open_s(a, 1'b0);
    xfer(v, 1'b1, d);
    close_s();
  endtask
  task automatic rd_reg(input logic [6:0] a, output logic [7:0] v);
    open_s(a, 1'b1);
    xfer(8'h00, 1'b0, v);
    close_s();
  endtask
endmodule // txpe_host_model
`default_nettype wire

//--- sim/tx_packet_engine_ctrl_tb_top.sv
// Register and packet tests of the transmit packet engine.
// Assumes host model tasks for all port traffic; lock detect set by tests.
`timescale 1ns/1ps
`default_nettype none
module tx_packet_engine_ctrl_tb_top;
  logic core_clk, sys_rst, port_select_low_n, serial_clk, serial_data_i;
  logic serial_data_o, serial_data_oe, lock_detect, tx_bit, mod_active;
  logic ready_strobe, amp_on, synth_on, xco_on, ref_out_en, buf_ready;
  logic [2:0] amp_level;
  logic [7:0] amp_bias_ctrl;
  int failures, tests_run, rdy_rises;
  logic rdy_q;
  logic [6:0] adr [6] = '{7'h00, 7'h0C, 7'h0D, 7'h17, 7'h1C, 7'h7E};
  logic [7:0] rst_v [6] = '{8'h7F, 8'h31, 8'hB6, 8'h99, 8'hE5, 8'h00};
  logic [7:0] exp_b [6] = '{8'hAA, 8'hC3, 8'h03, 8'h3C, 8'h96, 8'hEE};
  txpe_ctrl txpe_ctrl_i (.*);
  txpe_host_model txpe_host_model_i (.*);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (ready_strobe === 1'b1 && rdy_q === 1'b0)
      rdy_rises++;
    rdy_q = ready_strobe;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy(input logic lvl);
    int n;
    n = 0;
    while (ready_strobe !== lvl && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 20000) failures++;
  endtask
  task automatic summarize();
    $display("tests_run=%0d failures=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    summarize();
  end
  initial begin
    logic [7:0] rv;
    logic [7:0] acc;
    int n;
    failures = 0;
    tests_run = 0;
    rdy_rises = 0;
    rdy_q = 1'b0;
    sys_rst <= 1'b1;
    lock_detect <= 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(amp_bias_ctrl, 8'h99);
    for (int i = 0; i < 6; i++) begin
      txpe_host_model_i.rd_reg(adr[i], rv);
      chk(rv, rst_v[i]);
    end
    txpe_host_model_i.wr_reg(7'h17, 8'h5A);
    chk(amp_bias_ctrl, 8'h5A);
    txpe_host_model_i.rd_reg(7'h17, rv);
    chk(rv, 8'h5A);
    for (int i = 0; i < 4; i++) begin
      txpe_host_model_i.wr_reg(7'h00, {i[1:0], 6'h2F});
      chk({7'h0, xco_on}, {7'h0, i != 0});
      chk({7'h0, synth_on}, {7'h0, i == 3});
      chk({7'h0, ref_out_en}, {7'h0, i != 0});
    end
    chk({5'h0, amp_level}, 8'h05);
    chk({7'h0, amp_on}, 8'h01);
    txpe_host_model_i.wr_reg(7'h00, 8'hC7);
    chk({7'h0, amp_on}, 8'h00);
    txpe_host_model_i.wr_reg(7'h0C, 8'h33);
    chk({7'h0, amp_on}, 8'h01);
    lock_detect <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({7'h0, amp_on}, 8'h00);
    lock_detect <= 1'b1;
    txpe_host_model_i.wr_reg(7'h0D, 8'h20);
    txpe_host_model_i.wr_reg(7'h1C, 8'hC3);
    txpe_host_model_i.wr_reg(7'h0C, 8'h3D);
    txpe_host_model_i.wr_reg(7'h00, 8'hFF);
    chk({7'h0, synth_on & amp_on}, 8'h01);
    chk({5'h0, amp_level}, 8'h07);
    lock_detect <= 1'b0;
    fork
      begin
        txpe_host_model_i.open_s(7'h1D, 1'b0);
        txpe_host_model_i.xfer(8'h03, 1'b1, rv);
        repeat (20) @(posedge core_clk);
        chk({7'h0, mod_active}, 8'h00);
        lock_detect <= 1'b1;
        wait_rdy(1'b1);
        wait_rdy(1'b0);
        txpe_host_model_i.xfer(8'h3C, 1'b1, rv);
        wait_rdy(1'b1);
        wait_rdy(1'b0);
        txpe_host_model_i.xfer(8'h96, 1'b1, rv);
        txpe_host_model_i.close_s();
      end
      begin
        n = 0;
        while (mod_active !== 1'b1 && n < 4000) begin
          @(negedge core_clk);
          n++;
        end
        repeat (240) @(negedge core_clk);
        for (int i = 0; i < 48; i++) begin
          acc = {acc[6:0], tx_bit};
          if (i % 8 == 7) chk(acc, exp_b[i / 8]);
          repeat (160) @(negedge core_clk);
        end
      end
    join
    n = 0;
    while (mod_active !== 1'b0 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    repeat (4) @(negedge core_clk);
    chk({7'h0, mod_active}, 8'h00);
    chk({7'h0, amp_on}, 8'h00);
    chk({7'h0, synth_on}, 8'h01);
    chk(rdy_rises[7:0], 8'h05);
    chk({7'h0, buf_ready}, 8'h01);
    txpe_host_model_i.open_s(7'h1D, 1'b0);
    txpe_host_model_i.xfer(8'h02, 1'b1, rv);
    repeat (8) @(negedge core_clk);
    chk({7'h0, amp_on}, 8'h01);
    txpe_host_model_i.close_s();
    summarize();
  end
endmodule // tx_packet_engine_ctrl_tb_top
bind txpe_ctrl txpe_ctrl_asserts txpe_ctrl_asserts_i (.*);
`default_nettype wire
